// ===== rtl/sync_fault.sv
// multidevice sync via shared rate line and overrange fault pin
// assumes i_rate_line and i_overrange arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
module sync_fault
    import sync_fault_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_slave_mode,
    input wire logic i_serial_port_logic_reset,
    input wire logic [27:0] i_output_sample_rate,
    input wire logic i_rate_line,
    input wire logic i_overrange,
    input wire logic [DIAG_W-1:0] i_diag_err,
    input wire logic [DIAG_W-1:0] i_diag_en,
    input wire logic i_fault_pin_output_enable,
    input wire logic i_input_overrange_fault_route,
    input wire logic i_fault_pin_dir_out,
    output logic o_rate_line,
    output logic o_rate_line_oe,
    output logic o_fault_report_pin,
    output logic o_fault_report_pin_oe,
    output logic o_data_if_reset,
    output logic o_synced
);
    logic [1:0] line_sync_ff;
    logic [1:0] or_sync_ff;
    logic line_d_ff;
    logic fault_ff;
    logic if_rst_ff;
    sync_state_e state_ff;
    sync_state_e nxt_state;
    logic tick;

    // two flops per async pin; logic reads only the second
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            line_sync_ff <= 2'h0;
            or_sync_ff <= 2'h0;
            line_d_ff <= 1'b0;
        end else if (i_ce) begin
            line_sync_ff <= {line_sync_ff[0], i_rate_line};
            or_sync_ff <= {or_sync_ff[0], i_overrange};
            line_d_ff <= line_sync_ff[1];
        end
    end

    wire line_rise = line_sync_ff[1] && !line_d_ff;
    // out of range words are clamped, never refused
    wire [27:0] rate_clamped =
        (i_output_sample_rate < RATE_MIN) ? RATE_MIN :
        (i_output_sample_rate > RATE_MAX) ? RATE_MAX :
        i_output_sample_rate;
    // slaves realign on each shared line edge; master restarts on reset
    wire restart = if_rst_ff || (i_slave_mode && line_rise);

    rate_gen u_rate_gen (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_restart(restart),
        .i_rate(rate_clamped),
        .o_tick(tick)
    );

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (i_serial_port_logic_reset) nxt_state = ST_ARMED;
            // in slave mode armed waits for the first shared edge so all slaves start alike
            ST_ARMED: if (!i_slave_mode || line_rise) nxt_state = ST_RUN;
            ST_RUN: if (i_serial_port_logic_reset) nxt_state = ST_ARMED;
            default: nxt_state = ST_IDLE;
        endcase
    end

    wire diag_hit = |(i_diag_err & i_diag_en);
    wire or_hit = or_sync_ff[1] && i_input_overrange_fault_route;
    wire nxt_fault = i_fault_pin_output_enable && (diag_hit || or_hit);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= ST_IDLE;
            if_rst_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            if_rst_ff <= i_serial_port_logic_reset;
            fault_ff <= nxt_fault;
        end
    end

    assign o_data_if_reset = if_rst_ff;
    assign o_synced = (state_ff == ST_RUN);
    assign o_rate_line = tick;
    assign o_rate_line_oe = !i_slave_mode;
    assign o_fault_report_pin = fault_ff;
    assign o_fault_report_pin_oe = i_fault_pin_dir_out;

    // slave leaves armed on the first shared edge; the restart it issues
    // zeroes the accumulator, keeping all peers within one clock of phase
    property p_slave_align;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && i_slave_mode && state_ff == ST_ARMED && line_rise)
            |=> o_synced;
    endproperty
    a_slave_align: assert property (p_slave_align)
        else $error("slave did not realign on line edge");

    property p_if_reset;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && i_serial_port_logic_reset) |=> o_data_if_reset;
    endproperty
    a_if_reset: assert property (p_if_reset)
        else $error("interface reset not applied");

    property p_fault_or;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && or_sync_ff[1] && i_input_overrange_fault_route &&
         i_fault_pin_output_enable) |=> o_fault_report_pin;
    endproperty
    a_fault_or: assert property (p_fault_or)
        else $error("overrange did not raise fault pin");

    property p_fault_off;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && !i_fault_pin_output_enable) |=> !o_fault_report_pin;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("fault pin high while disabled");

    property p_diag;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && i_fault_pin_output_enable && diag_hit) |=> o_fault_report_pin;
    endproperty
    a_diag: assert property (p_diag)
        else $error("diagnostic error not reported");

    property p_route;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && !i_input_overrange_fault_route && !diag_hit)
            |=> !o_fault_report_pin;
    endproperty
    a_route: assert property (p_route)
        else $error("overrange reported without route");

    property p_rate_range;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        rate_clamped >= RATE_MIN && rate_clamped <= RATE_MAX;
    endproperty
    a_rate_range: assert property (p_rate_range)
        else $error("rate outside range");

    property p_line_oe;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        i_slave_mode |-> !o_rate_line_oe;
    endproperty
    a_line_oe: assert property (p_line_oe)
        else $error("slave drives shared rate line");

    // a master has no line to wait for and runs at once
    property p_master_run;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && !i_slave_mode && state_ff == ST_ARMED) |=> o_synced;
    endproperty
    a_master_run: assert property (p_master_run)
        else $error("master did not leave armed state");

    property p_armed_wait;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && i_slave_mode && state_ff == ST_ARMED && !line_rise)
            |=> !o_synced;
    endproperty
    a_armed_wait: assert property (p_armed_wait)
        else $error("slave synced without a line edge");

    property p_rearm;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && state_ff == ST_RUN && i_serial_port_logic_reset)
            |=> !o_synced;
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("interface reset did not drop sync");

    // the reset request is a single cycle wide, so is the answer
    property p_if_reset_pulse;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && o_data_if_reset && !i_serial_port_logic_reset)
            |=> !o_data_if_reset;
    endproperty
    a_if_reset_pulse: assert property (p_if_reset_pulse)
        else $error("interface reset held too long");

    // fault reporting is level only: nothing is latched once a cause ends
    property p_fault_clear;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && !or_sync_ff[1] && !diag_hit) |=> !o_fault_report_pin;
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("fault pin stuck after cause cleared");

    // clock enable low freezes every state bit
    property p_ce_freeze;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !i_ce |=> $stable(state_ff) && $stable(if_rst_ff) &&
            $stable(fault_ff) && $stable(line_sync_ff);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state changed with clock enable low");

    c_sync: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
        state_ff == ST_ARMED ##1 state_ff == ST_RUN);
    c_fault: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(o_fault_report_pin));
    c_tick: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
        tick);
    c_realign: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_slave_mode && line_rise);
    c_if_reset: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_data_if_reset);
endmodule : sync_fault
`default_nettype wire

// ===== rtl/sync_fault_pkg.sv
// constants for the multidevice sync and overrange fault block
// assumes a single 40 MHz system clock, no register bus
package sync_fault_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned PERIOD_NS = 25;
    // rate word in 0.01 sps units
    localparam int unsigned RATE_W = 28;
    localparam logic [27:0] RATE_MIN = 28'h00003e8;
    localparam logic [27:0] RATE_MAX = 28'h8eab700;
    localparam logic [27:0] RATE_RST = 28'h23aadc0;
    // accumulator modulus: clk rate in 0.01 sps units
    localparam logic [31:0] ACC_MOD = 32'hee6b2800;
    localparam int unsigned PHASE_MAX_NS = 10;
    localparam int unsigned PHASE_MAX_CYC =
        (PHASE_MAX_NS / PERIOD_NS) < 1 ? 1 : (PHASE_MAX_NS / PERIOD_NS);
    localparam int unsigned DIAG_W = 4;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} sync_state_e;
endpackage : sync_fault_pkg

// ===== rtl/rate_gen.sv
// phase accumulator producing the output_sample_rate strobe
// assumes clamped rate word; restart aligns phase to zero
`timescale 1ns/1ps
`default_nettype none
module rate_gen
    import sync_fault_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_restart,
    input wire logic [27:0] i_rate,
    output logic o_tick
);
    logic [32:0] acc_ff;
    logic tick_ff;
    wire [32:0] sum = acc_ff + {5'h00, i_rate};
    wire wrap = sum >= {1'b0, ACC_MOD};
    wire [32:0] nxt_acc = wrap ? sum - {1'b0, ACC_MOD} : sum;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_ff <= '0;
            tick_ff <= 1'b0;
        end else if (i_ce) begin
            acc_ff <= i_restart ? 33'h0 : nxt_acc;
            tick_ff <= !i_restart && wrap;
        end
    end
    // restart lands the phase on zero with no tick, so peers start alike
    property p_restart;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && i_restart) |=> (acc_ff == 33'h0 && !tick_ff);
    endproperty
    a_restart: assert property (p_restart)
        else $error("accumulator not restarted");
    assign o_tick = tick_ff;
endmodule : rate_gen
`default_nettype wire

// ===== tb/peer_dev.sv
// peer converter in master mode driving the shared rate line
// assumes the bench clock; the line idles low between ticks
`timescale 1ns/1ps
`default_nettype none
module peer_dev (
    input wire logic i_clk,
    input wire logic i_fire,
    output logic o_line
);
    // one-cycle tick per output sample; the block still treats the line
    // as asynchronous and passes it through its own synchroniser
    always @(posedge i_clk) begin
        o_line <= i_fire;
    end
endmodule : peer_dev
`default_nettype wire

// ===== tb/multidevice_sync_and_overrange_flag_tb_top.sv
// bench for sync_fault with a peer converter on the rate line
// assumes a 40 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module multidevice_sync_and_overrange_flag_tb_top;
    import sync_fault_pkg::*;
    logic clk, nrst, ce, slv, sprst, ovr, foe, route, dir, fire;
    logic [27:0] rate;
    logic [DIAG_W-1:0] derr, den;
    logic rl, rl_oe, fp, fp_oe, dif, syn, line;
    int n_fail = 0;
    int n_compared = 0;
    sync_fault dut_u (.i_sys_clk(clk), .i_nrst(nrst), .i_ce(ce),
        .i_slave_mode(slv), .i_serial_port_logic_reset(sprst),
        .i_output_sample_rate(rate), .i_rate_line(line), .i_overrange(ovr),
        .i_diag_err(derr), .i_diag_en(den), .i_fault_pin_output_enable(foe),
        .i_input_overrange_fault_route(route), .i_fault_pin_dir_out(dir),
        .o_rate_line(rl), .o_rate_line_oe(rl_oe), .o_fault_report_pin(fp),
        .o_fault_report_pin_oe(fp_oe), .o_data_if_reset(dif),
        .o_synced(syn));
    peer_dev peer_u (.i_clk(clk), .i_fire(fire), .o_line(line));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    // one broadcast pulse, counted over a short window
    task automatic t_ifreset;
        int cnt;
        cnt = 0;
        sprst = 1'b1;
        repeat (4) begin
            @(negedge clk);
            sprst = 1'b0;
            cnt += int'(dif);
        end
        chk(16'(cnt), 16'h1);
    endtask : t_ifreset
    task automatic t_sync;
        int n;
        chk({15'h0, syn}, 16'h0);
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
        for (n = 0; n < 6 && syn !== 1'b1; n++) @(negedge clk);
        chk({15'h0, syn}, 16'h1);
        if (syn !== 1'b1) final_report();
    endtask : t_sync
    task automatic t_fault(input logic [4:0] cfg, input logic exp);
        {foe, route, ovr, derr[1], den[1]} = cfg;
        repeat (5) @(negedge clk);
        chk({15'h0, fp}, {15'h0, exp});
    endtask : t_fault
    // tick count over n cycles; exact rate arithmetic bounds it
    task automatic t_rate(input logic [27:0] r, input int n, input int lo);
        int cnt;
        cnt = 0;
        rate = r;
        repeat (40) @(negedge clk);
        repeat (n) begin
            @(negedge clk);
            cnt += int'(rl);
        end
        chk({15'h0, cnt == lo || cnt == lo + 1}, 16'h1);
    endtask : t_rate
    // slow rates tick too rarely to count; watch the phase step instead
    task automatic t_rate_min(input logic [27:0] r);
        logic [32:0] a0;
        rate = r;
        sprst = 1'b1;
        @(negedge clk);
        sprst = 1'b0;
        repeat (3) @(negedge clk);
        a0 = dut_u.u_rate_gen.acc_ff;
        repeat (50) @(negedge clk);
        chk(16'(dut_u.u_rate_gen.acc_ff - a0), 16'(50 * RATE_MIN));
    endtask : t_rate_min
    // requests are not taken while the clock enable is low
    task automatic t_ce;
        ce = 1'b0;
        sprst = 1'b1;
        @(negedge clk);
        sprst = 1'b0;
        repeat (3) @(negedge clk);
        chk({14'h0, dif, syn}, 16'h1);
        ce = 1'b1;
        @(negedge clk);
        chk({14'h0, dif, syn}, 16'h1);
    endtask : t_ce
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {nrst, sprst, ovr, foe, route, fire, derr, den} = '0;
        ce = 1'b1;
        {slv, dir} = 2'b11;
        rate = RATE_RST;
        repeat (3) @(negedge clk);
        chk({12'h0, rl, fp, dif, syn}, 16'h0);
        chk({14'h0, rl_oe, fp_oe}, 16'h1);
        nrst = 1'b1;
        t_ifreset();
        t_sync();
        t_fault(5'b11100, 1'b1);
        t_fault(5'b10100, 1'b0);
        t_fault(5'b01100, 1'b0);
        t_fault(5'b11000, 1'b0);
        t_fault(5'b10011, 1'b1);
        t_fault(5'b10010, 1'b0);
        t_fault(5'b00011, 1'b0);
        dir = 1'b0;
        slv = 1'b0;
        @(negedge clk);
        chk({14'h0, rl_oe, fp_oe}, 16'h2);
        t_ifreset();
        t_ce();
        t_rate(RATE_MAX, 4000, 149);
        t_rate(28'hfffffff, 4000, 149);
        t_rate_min(RATE_MIN);
        t_rate_min(28'h0000000);
        final_report();
    end
endmodule : multidevice_sync_and_overrange_flag_tb_top
`default_nettype wire
